/* dtm_pkg.sv */
package dtm_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int POWERUP_WAIT_US = 100;
  localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES = 8;
  localparam int COUNTER_TEST_PRECHARGE_NS = 50;
  localparam int CPT_CYC = (COUNTER_TEST_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_COLUMN_SETUP_NS = 10;
  localparam int CSR_CYC = (REFRESH_COLUMN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_PULSE_NS = 100;
  localparam int RAS_CYC = (RAS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_PRECHARGE_NS = 70;
  localparam int RP_CYC = (RAS_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 4;
  localparam int CNT_W = 12;
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_EARLY_WRITE = 3'h1;
  localparam logic [2:0] OP_RMW = 3'h2;
  localparam logic [2:0] OP_REFRESH = 3'h3;
  localparam logic [2:0] OP_TEST_ENTER = 3'h4;
  localparam logic [2:0] OP_TEST_EXIT = 3'h5;
  localparam logic [2:0] OP_COUNTER_TEST = 3'h6;
  localparam logic [2:0] OP_MASK_WRITE = 3'h7;
  typedef enum logic [3:0] {
    DTM_IDLE, DTM_RAS_SETUP, DTM_RAS_LOW, DTM_CAS_LOW, DTM_WE_LOW,
    DTM_CBR_CAS, DTM_CBR_RAS, DTM_CPT, DTM_END, DTM_PRECHARGE
  } dtm_state_e;
endpackage

/* dtm_timer_if.sv */
`timescale 1ns/1ps
interface dtm_timer_if;
  logic                   load;
  logic [dtm_pkg::CNT_W-1:0] value;
  logic                   done;
  modport owner (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface

/* dtm_timer.sv */
`timescale 1ns/1ps
module dtm_timer (
  input wire logic  mclk,
  input wire logic  sys_rst,
  dtm_timer_if.timer tif
);
  logic [dtm_pkg::CNT_W-1:0] cnt_ff;
  logic [dtm_pkg::CNT_W-1:0] nxt_cnt;

  always_comb begin
    if (tif.load) begin
      nxt_cnt = tif.value;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // done ignores load so the owner's next-state logic never loops back through it
  assign tif.done = (cnt_ff == '0);
endmodule // dtm_timer

/* dtm_ctrl.sv */
`timescale 1ns/1ps
// Function
// RULE_01: early write lowers write enable before column strobe; device output floats.
// RULE_02: read-modify-write lowers write enable late, after read data sampled.
// RULE_03: other write enable timing gives undefined data; avoided by construction.
// RULE_04: write data held stable across column strobe or write enable fall.
// RULE_05: read data sampled only after column strobe held its access time.
// RULE_06: wait 100 us after reset, then issue eight init refresh cycles.
// RULE_07: init refreshes are column-before-row, so internal counter is usable.
// RULE_08: output enable released before write data is driven in delayed writes.
// RULE_09: test mode compares two bits selected by control address bit zero.
// RULE_10: test entry lowers write enable and column strobe before row strobe.
// RULE_11: in test mode refresh only with reads or test entry cycles.
// RULE_12: in test mode a high read bit means compared bits were equal.
// RULE_13: test exit is column-before-row refresh with write enable high.
// RULE_14: mask write holds mask-select low as row strobe falls.
// RULE_15: mask is driven on data pins at row strobe fall; high bits write.
// RULE_16: counter test holds column strobe precharged at least 50 ns.
// RULE_17: column strobe falls at least 10 ns before row strobe in refresh.
// RULE_18: device takes refresh row from its own counter; address is don't care.
module dtm_ctrl (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        req_valid,
  input  wire logic [2:0]                  req_op,
  input  wire logic [dtm_pkg::ADDR_W-1:0]  req_row,
  input  wire logic [dtm_pkg::ADDR_W-1:0]  req_col,
  input  wire logic [dtm_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic [dtm_pkg::DATA_W-1:0]  req_mask,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [dtm_pkg::DATA_W-1:0]       rsp_rdata,
  output logic                             init_done,
  output logic                             test_mode,
  output logic                             ras_n,
  output logic                             cas_n,
  output logic                             mask_select_write_n,
  output logic                             oe_n,
  output logic [dtm_pkg::ADDR_W-1:0]       addr,
  output logic [dtm_pkg::DATA_W-1:0]       mask_data_line_out,
  output logic                             mask_data_line_oe,
  input  wire logic [dtm_pkg::DATA_W-1:0]  mask_data_line_in
);
  dtm_timer_if tif ();
  dtm_timer u_timer (.mclk(mclk), .sys_rst(sys_rst), .tif(tif));

  logic [dtm_pkg::DATA_W-1:0] din_meta_ff;
  logic [dtm_pkg::DATA_W-1:0] din_sync_ff;

  dtm_pkg::dtm_state_e        st_ff, nxt_st;
  logic [2:0]                 op_ff, nxt_op;
  logic [dtm_pkg::ADDR_W-1:0] col_ff, nxt_col;
  logic [dtm_pkg::DATA_W-1:0] wd_ff, nxt_wd;
  logic [3:0]                 init_cnt_ff, nxt_init_cnt;
  logic                       init_ff, nxt_init;
  logic                       pwr_wait_ff, nxt_pwr_wait;
  logic                       test_ff, nxt_test;
  logic                       rdy_ff, nxt_rdy;
  logic                       rv_ff, nxt_rv;
  logic [dtm_pkg::DATA_W-1:0] rd_ff, nxt_rd;
  logic                       ras_ff, nxt_ras;
  logic                       cas_ff, nxt_cas;
  logic                       we_ff, nxt_we;
  logic                       oe_ff, nxt_oe;
  logic [dtm_pkg::ADDR_W-1:0] a_ff, nxt_a;
  logic [dtm_pkg::DATA_W-1:0] dq_ff, nxt_dq;
  logic                       dqoe_ff, nxt_dqoe;
  logic                       tload;
  logic [dtm_pkg::CNT_W-1:0]  tval;
  logic                       boot_ff;

  assign tif.load  = tload;
  assign tif.value = tval;

  // pins sampled through two flops; read data is only taken well after access time
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      din_meta_ff <= '0;
      din_sync_ff <= '0;
    end else begin
      din_meta_ff <= mask_data_line_in;
      din_sync_ff <= din_meta_ff;
    end
  end

  function automatic logic [dtm_pkg::CNT_W-1:0] cyc(input int n);
    cyc = (dtm_pkg::CNT_W)'(n);
  endfunction

  always_comb begin
    nxt_st = st_ff; nxt_op = op_ff; nxt_col = col_ff; nxt_wd = wd_ff;
    nxt_init_cnt = init_cnt_ff; nxt_init = init_ff; nxt_pwr_wait = pwr_wait_ff;
    nxt_test = test_ff; nxt_rdy = 1'b0; nxt_rv = 1'b0; nxt_rd = rd_ff;
    nxt_ras = ras_ff; nxt_cas = cas_ff; nxt_we = we_ff; nxt_oe = oe_ff;
    nxt_a = a_ff; nxt_dq = dq_ff; nxt_dqoe = dqoe_ff;
    tload = 1'b0; tval = '0;
    case (st_ff)
      dtm_pkg::DTM_IDLE: begin
        if (pwr_wait_ff) begin
          if (tif.done) begin
            nxt_pwr_wait = 1'b0; // RULE_06
          end
        end else if (!init_ff) begin
          nxt_op = dtm_pkg::OP_REFRESH; // RULE_07
          nxt_cas = 1'b0; // RULE_17
          tload = 1'b1; tval = cyc(dtm_pkg::CSR_CYC);
          nxt_st = dtm_pkg::DTM_CBR_CAS;
        end else if (req_valid && !rdy_ff) begin
          nxt_rdy = 1'b1;
          nxt_op = req_op; nxt_col = req_col; nxt_wd = req_wdata;
          nxt_a = req_row; // RULE_18
          tload = 1'b1; tval = cyc(dtm_pkg::CSR_CYC);
          case (req_op)
            dtm_pkg::OP_REFRESH, dtm_pkg::OP_TEST_EXIT, dtm_pkg::OP_COUNTER_TEST: begin
              nxt_cas = 1'b0; // RULE_17
              nxt_we = 1'b1; // RULE_13
              nxt_st = dtm_pkg::DTM_CBR_CAS;
            end
            dtm_pkg::OP_TEST_ENTER: begin
              nxt_cas = 1'b0; // RULE_10
              nxt_we = 1'b0; // RULE_10
              nxt_st = dtm_pkg::DTM_CBR_CAS;
            end
            dtm_pkg::OP_MASK_WRITE: begin
              nxt_we = 1'b0; // RULE_14
              nxt_dq = req_mask; // RULE_15
              nxt_dqoe = 1'b1;
              nxt_st = dtm_pkg::DTM_RAS_SETUP;
            end
            default: begin
              nxt_st = dtm_pkg::DTM_RAS_SETUP;
            end
          endcase
        end
      end
      dtm_pkg::DTM_RAS_SETUP: begin
        nxt_ras = 1'b0; // RULE_14
        nxt_st = dtm_pkg::DTM_RAS_LOW;
      end
      dtm_pkg::DTM_RAS_LOW: begin
        nxt_a = col_ff;
        nxt_we = 1'b1;
        nxt_dqoe = 1'b0;
        if (op_ff == dtm_pkg::OP_EARLY_WRITE || op_ff == dtm_pkg::OP_MASK_WRITE) begin
          nxt_we = 1'b0; // RULE_01
          nxt_dq = wd_ff; // RULE_04
          nxt_dqoe = 1'b1;
        end else begin
          nxt_oe = 1'b0;
        end
        nxt_st = dtm_pkg::DTM_CAS_LOW;
      end
      dtm_pkg::DTM_CAS_LOW: begin
        nxt_cas = 1'b0;
        tload = 1'b1; tval = cyc(dtm_pkg::RAS_CYC);
        nxt_st = dtm_pkg::DTM_WE_LOW;
      end
      dtm_pkg::DTM_WE_LOW: begin
        // two sync flops plus access time fit inside the strobe pulse
        if (tif.done) begin
          if (op_ff == dtm_pkg::OP_READ || op_ff == dtm_pkg::OP_RMW) begin
            nxt_rd = din_sync_ff; // RULE_05 RULE_12
            nxt_rv = 1'b1;
          end
          if (op_ff == dtm_pkg::OP_RMW) begin
            nxt_oe = 1'b1; // RULE_08
            nxt_dq = wd_ff;
            tload = 1'b1; tval = cyc(dtm_pkg::CSR_CYC);
            nxt_st = dtm_pkg::DTM_END;
            nxt_op = dtm_pkg::OP_EARLY_WRITE;
          end else begin
            nxt_st = dtm_pkg::DTM_PRECHARGE;
          end
        end
      end
      dtm_pkg::DTM_END: begin
        // data driven a cycle after buffer release, then write enable falls
        if (!dqoe_ff) begin
          nxt_dqoe = 1'b1;
        end else begin
          nxt_we = 1'b0; // RULE_02 RULE_03 RULE_04
          tload = 1'b1; tval = cyc(dtm_pkg::CSR_CYC);
          nxt_st = dtm_pkg::DTM_WE_LOW;
        end
      end
      dtm_pkg::DTM_CBR_CAS: begin
        if (tif.done) begin
          nxt_ras = 1'b0;
          tload = 1'b1; tval = cyc(dtm_pkg::RAS_CYC);
          nxt_st = dtm_pkg::DTM_CBR_RAS;
        end
      end
      dtm_pkg::DTM_CBR_RAS: begin
        if (tif.done) begin
          nxt_we = 1'b1;
          if (op_ff == dtm_pkg::OP_COUNTER_TEST) begin
            nxt_cas = 1'b1; // RULE_16
            tload = 1'b1; tval = cyc(dtm_pkg::CPT_CYC);
            nxt_op = dtm_pkg::OP_READ;
            nxt_st = dtm_pkg::DTM_CPT;
          end else begin
            if (op_ff == dtm_pkg::OP_TEST_ENTER) begin
              nxt_test = 1'b1; // RULE_09 RULE_11
            end else begin
              nxt_test = 1'b0; // RULE_13
            end
            if (!init_ff) begin
              nxt_init_cnt = init_cnt_ff + 4'h1;
              nxt_init = (init_cnt_ff == 4'(dtm_pkg::INIT_CYCLES - 1)); // RULE_06
            end
            nxt_st = dtm_pkg::DTM_PRECHARGE;
          end
        end
      end
      dtm_pkg::DTM_CPT: begin
        if (tif.done) begin
          nxt_a = col_ff;
          nxt_oe = 1'b0;
          nxt_st = dtm_pkg::DTM_CAS_LOW;
        end
      end
      dtm_pkg::DTM_PRECHARGE: begin
        nxt_ras = 1'b1; nxt_cas = 1'b1; nxt_we = 1'b1; nxt_oe = 1'b1;
        nxt_dqoe = 1'b0;
        if (ras_ff) begin
          if (tif.done) begin
            nxt_st = dtm_pkg::DTM_IDLE;
          end
        end else begin
          tload = 1'b1; tval = cyc(dtm_pkg::RP_CYC);
        end
      end
      default: nxt_st = dtm_pkg::DTM_IDLE;
    endcase
    if (boot_ff) begin
      tload = 1'b1; // RULE_06
      tval  = cyc(dtm_pkg::POWERUP_WAIT_CYC);
    end
  end

  // power-up pause loads once right after reset release
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= dtm_pkg::DTM_IDLE; op_ff <= '0; col_ff <= '0; wd_ff <= '0;
      init_cnt_ff <= '0; init_ff <= 1'b0; pwr_wait_ff <= 1'b1; test_ff <= 1'b0;
      rdy_ff <= 1'b0; rv_ff <= 1'b0; rd_ff <= '0;
      ras_ff <= 1'b1; cas_ff <= 1'b1; we_ff <= 1'b1; oe_ff <= 1'b1;
      a_ff <= '0; dq_ff <= '0; dqoe_ff <= 1'b0;
    end else begin
      st_ff <= boot_ff ? dtm_pkg::DTM_IDLE : nxt_st;
      op_ff <= nxt_op; col_ff <= nxt_col; wd_ff <= nxt_wd;
      init_cnt_ff <= nxt_init_cnt; init_ff <= nxt_init;
      pwr_wait_ff <= boot_ff ? 1'b1 : nxt_pwr_wait; test_ff <= nxt_test;
      rdy_ff <= nxt_rdy; rv_ff <= nxt_rv; rd_ff <= nxt_rd;
      ras_ff <= nxt_ras; cas_ff <= nxt_cas; we_ff <= nxt_we; oe_ff <= nxt_oe;
      a_ff <= nxt_a; dq_ff <= nxt_dq; dqoe_ff <= nxt_dqoe;
    end
  end

  // timer is loaded with the power-up pause on the boot cycle
  assign req_ready           = rdy_ff;
  assign rsp_valid           = rv_ff;
  assign rsp_rdata           = rd_ff;
  assign init_done           = init_ff;
  assign test_mode           = test_ff;
  assign ras_n               = ras_ff;
  assign cas_n               = cas_ff;
  assign mask_select_write_n = we_ff;
  assign oe_n                = oe_ff;
  assign addr                = a_ff;
  assign mask_data_line_out  = dq_ff;
  assign mask_data_line_oe   = dqoe_ff;
endmodule // dtm_ctrl

/* dtm_monitor.sv */
`timescale 1ns/1ps
module dtm_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic req_ready,
  input wire logic init_done,
  input wire logic test_mode,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic mask_select_write_n,
  input wire logic oe_n,
  input wire logic mask_data_line_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic       ras_d_ff;
  logic [3:0] cbr_ff;
  logic [3:0] nxt_cbr;
  logic [11:0] pwr_cnt_ff;
  logic [11:0] nxt_pwr_cnt;
  // saturating count of refreshes since reset
  always_comb begin
    nxt_cbr = cbr_ff;
    // cycles since reset, saturating; no row strobe before the power-up pause is over
    nxt_pwr_cnt = pwr_cnt_ff;
    if (pwr_cnt_ff != 12'hFFF) nxt_pwr_cnt = pwr_cnt_ff + 12'h001;
    if (ras_d_ff && !ras_n && !cas_n && cbr_ff != 4'hF) nxt_cbr = cbr_ff + 4'h1;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ras_d_ff <= 1'b1;
      cbr_ff <= 4'h0;
      pwr_cnt_ff <= 12'h000;
    end else begin
      ras_d_ff <= ras_n;
      cbr_ff <= nxt_cbr;
      pwr_cnt_ff <= nxt_pwr_cnt;
    end
  end
  sequence s_cbr; $fell(ras_n) && !cas_n; endsequence
  sequence s_write_column_before_row_cycle; s_cbr ##0 !mask_select_write_n; endsequence
  sequence s_exit; s_cbr ##0 (mask_select_write_n && test_mode); endsequence
  property p_csr; s_cbr |-> $past(cas_n) == 1'b0; endproperty
  property p_init_cbr; $fell(ras_n) && !init_done |-> !cas_n; endproperty
  property p_init_cnt; $rose(init_done) |-> cbr_ff >= 4'h8; endproperty
  property p_no_early; !init_done |-> !req_ready; endproperty
  property p_oe_data; mask_data_line_oe |-> oe_n; endproperty
  property p_mask; $fell(ras_n) && cas_n && !mask_select_write_n |-> mask_data_line_oe; endproperty
  property p_enter; s_write_column_before_row_cycle |-> ##[1:20] test_mode; endproperty
  property p_exit; s_exit |-> ##[1:20] !test_mode; endproperty
  property p_cpt; !ras_n && $rose(cas_n) |=> cas_n; endproperty
  property p_pause; $fell(ras_n) |-> pwr_cnt_ff >= 12'(dtm_pkg::POWERUP_WAIT_CYC); endproperty
  a_pause: assert property (p_pause)
    else $error("row strobe before power-up pause ended");
  a_csr: assert property (p_csr)
    else $error("column strobe not set up before row strobe");
  a_init_cbr: assert property (p_init_cbr)
    else $error("init refresh is not column-before-row");
  a_init_cnt: assert property (p_init_cnt)
    else $error("init done after fewer than eight refreshes");
  a_no_early: assert property (p_no_early)
    else $error("request taken before init done");
  a_oe_data: assert property (p_oe_data)
    else $error("data driven while output enable active");
  a_mask: assert property (p_mask)
    else $error("mask not driven at row strobe fall");
  a_enter: assert property (p_enter)
    else $error("test mode not entered");
  a_exit: assert property (p_exit)
    else $error("test mode not left");
  a_cpt: assert property (p_cpt)
    else $error("column precharge too short");
endmodule // dtm_monitor

/* dtm_dram_model.sv */
`timescale 1ns/1ps
module dtm_dram_model #(parameter int ACC_NS = 20) (
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       mask_select_write_n,
  input wire logic       oe_n,
  input wire logic [9:0] addr,
  input wire logic [3:0] dq,
  output logic [3:0]     q,
  output logic           q_oe
);
  logic [3:0] mem [int];
  logic [9:0] row;
  logic [3:0] msk = 4'hF;
  logic [3:0] rd = 4'h0;
  logic       early = 0;
  logic       cas_seen = 0;
  logic       tst = 0;
  int         k;
  int         ctr = 0;
  int         cbr_cnt = 0;
  function automatic logic [3:0] rdm(int a);
    return mem.exists(a) ? mem[a] : 4'h0;
  endfunction
  task automatic wr(int a, logic [3:0] d);
    mem[a] = (d & msk) | (rdm(a) & ~msk);
  endtask
  always @(negedge ras_n) begin
    row = addr;
    msk = 4'hF;
    early = 0;
    cas_seen = !cas_n;
    if (!cas_n) begin
      ctr = ctr + 1;
      cbr_cnt++;
      tst = !mask_select_write_n;
    end else if (!mask_select_write_n) msk = dq;
  end
  // a row-only cycle with no column access ends test mode
  always @(posedge ras_n) if (!cas_seen) tst = 0;
  always @(negedge cas_n) if (!ras_n) begin
    cas_seen = 1;
    k = {row, addr};
    early = !mask_select_write_n;
    if (early) wr(k, dq);
    else rd = tst ? {4{rdm(k & ~1) == rdm(k | 1)}} : rdm(k);
  end
  // a write enable fall after the column strobe leaves the output undefined
  always @(negedge mask_select_write_n) if (!cas_n && !ras_n) begin
    wr(k, dq);
    rd = 'x;
  end
  wire drv = !ras_n && !cas_n && !oe_n && !early && cas_seen;
  // turn-on waits the access time, turn-off is fast
  always @(drv or rd) begin
    q_oe <= #(drv ? ACC_NS : 1) drv;
    q <= #ACC_NS rd;
  end
endmodule // dtm_dram_model

/* dtm_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic       mclk = 0;
  logic       sys_rst = 1;
  logic       req_valid = 0;
  logic [2:0] req_op = 0;
  logic [9:0] req_row = 0, req_col = 0, addr, r, c;
  logic [3:0] req_wdata = 0, req_mask = 0, idle_pat = 4'h5, w, m;
  logic       req_ready, rsp_valid, init_done, test_mode, ras_n, cas_n, oe_n;
  logic       mask_select_write_n, d_oe, m_oe;
  logic [3:0] rsp_rdata, d_q, m_q, dq;
  logic [7:0] e;
  logic [7:0] expq [$];
  logic [3:0] shadow [int];
  int         err_count = 0, n_tests = 0, i, j;
  always #25 mclk = ~mclk;
  // undriven lines flip every cycle so stale data never looks valid
  always @(negedge mclk) idle_pat <= ~dq;
  assign dq = d_oe ? d_q : (m_oe ? m_q : idle_pat);
  dtm_ctrl i_dut (.mclk, .sys_rst, .req_valid, .req_op, .req_row, .req_col, .req_wdata,
    .req_mask, .req_ready, .rsp_valid, .rsp_rdata, .init_done, .test_mode, .ras_n, .cas_n,
    .mask_select_write_n, .oe_n, .addr, .mask_data_line_out(d_q), .mask_data_line_oe(d_oe),
    .mask_data_line_in(dq));
  dtm_dram_model #(.ACC_NS(40)) i_mem (.ras_n, .cas_n, .mask_select_write_n, .oe_n, .addr,
    .dq, .q(m_q), .q_oe(m_oe));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic req(input logic [2:0] op, input logic [9:0] rr, cc, input logic [3:0] ww,
                     input logic [3:0] mm, input logic [7:0] ee);
    int n;
    @(negedge mclk);
    {req_op, req_row, req_col, req_wdata, req_mask} = {op, rr, cc, ww, mm};
    req_valid = 1;
    if (op == 3'h0 || op == 3'h2 || op == 3'h6) expq.push_back(ee);
    n = 0;
    do begin @(negedge mclk); n++; end while (req_ready !== 1'b1 && n < 400);
    if (n >= 400) begin err_count++; $display("ERROR req_ready timeout"); complete_run(); end
    req_valid = 0;
  endtask
  task automatic wr(input logic [2:0] op, input logic [9:0] rr, cc, input logic [3:0] ww, mm);
    logic [3:0] o;
    o = shadow.exists({rr, cc}) ? shadow[{rr, cc}] : 4'h0;
    req(op, rr, cc, ww, mm, {4'hF, o});
    shadow[{rr, cc}] = (ww & mm) | (o & ~mm);
  endtask
  task automatic wait_tm(input logic v);
    for (j = 0; j < 40 && test_mode !== v; j++) @(negedge mclk);
    `CHK("test_mode", v, test_mode)
    $display("test mode step finished");
  endtask
  always @(negedge mclk) if (rsp_valid === 1'b1) begin
    if (expq.size() == 0) begin err_count++; $display("ERROR rsp_rdata unexpected"); end
    else begin
      e = expq.pop_front();
      `CHK("rsp_rdata", e[3:0] & e[7:4], rsp_rdata & e[7:4])
    end
  end
  initial begin
    void'($urandom(86018));
    repeat (20) @(posedge mclk);
    `CHK("strobes idle", 1'b1, ras_n & cas_n & oe_n & ~d_oe)
    @(negedge mclk) sys_rst = 0;
    for (i = 0; i < 6000 && init_done !== 1'b1; i++) @(negedge mclk);
    `CHK("init_done", 1'b1, init_done)
    `CHK("init refreshes", 1'b1, i_mem.cbr_cnt >= 8)
    $display("init test finished");
    for (i = 0; i < 6; i++) begin
      {r, c, w, m} = 28'($urandom);
      wr(3'h1, r, c, w, 4'hF);
      wr(3'h2, r, c, ~w, 4'hF);
      wr(3'h7, r, c, w, m);
      req(3'h0, r, c, 4'h0, 4'h0, {4'hF, shadow[{r, c}]});
    end
    $display("access test finished");
    req(3'h3, 10'h000, 10'h000, 4'h0, 4'h0, 8'h00);
    req(3'h6, 10'h000, 10'h000, 4'h0, 4'h0, 8'h00);
    wr(3'h1, 10'h007, 10'h002, 4'h5, 4'hF);
    wr(3'h1, 10'h007, 10'h003, 4'h5, 4'hF);
    wr(3'h1, 10'h007, 10'h004, 4'h1, 4'hF);
    wr(3'h1, 10'h007, 10'h005, 4'h2, 4'hF);
    req(3'h4, 10'h000, 10'h000, 4'h0, 4'h0, 8'h00);
    wait_tm(1'b1);
    req(3'h0, 10'h007, 10'h002, 4'h0, 4'h0, 8'hFF);
    req(3'h0, 10'h007, 10'h004, 4'h0, 4'h0, 8'hF0);
    req(3'h5, 10'h000, 10'h000, 4'h0, 4'h0, 8'h00);
    wait_tm(1'b0);
    req(3'h0, 10'h007, 10'h004, 4'h0, 4'h0, 8'hF1);
    for (i = 0; i < 200 && expq.size() != 0; i++) @(negedge mclk);
    `CHK("responses left", 0, expq.size())
    complete_run();
  end
endmodule // testbench
bind dtm_ctrl dtm_monitor i_mon (.mclk, .sys_rst, .req_ready, .init_done, .test_mode, .ras_n,
  .cas_n, .mask_select_write_n, .oe_n, .mask_data_line_oe);
